// File: spa_pkg.sv
// constants and types for the stack pointer address unit
//
// What this block does
// [RQ1] Every stack grows downward from the top of its area toward lower addresses.
// [RQ2] The pointer register always holds the address of the last item stored.
// [RQ3] Any register except register 7, the program counter, may act as a stack pointer.
// [RQ4] Call and interrupt sequences use register 6 as the stack pointer implicitly.
// [RQ5] Non-system stacks take words or bytes; the system stack takes words only.
// [RQ6] A push lowers the pointer first, then writes the item at the new address.
// [RQ7] A pop reads at the current address, then raises the pointer past the item.
// [RQ8] The system stack register holds even, word-aligned addresses, except after a call or return that names register 6 as the linkage register.
// [RQ9] A call pushes the linkage register, loads it with the return address, jumps; the unit does not jump, target_q is captured but never used.
// [RQ10] A return copies the linkage register to the counter, then pops into it; the unit skips the copy, it only pops into the linkage register.
// [RQ11] Steps are two for words and one for bytes; the system stack always steps two.
package spa_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned REG_W = 3;
  localparam logic [REG_W-1:0] SYS_STACK_REG = 3'h6;
  localparam logic [REG_W-1:0] INSTR_COUNTER_REG = 3'h7;
  localparam logic [DATA_W-1:0] WORD_STEP = 16'h0002;
  localparam logic [DATA_W-1:0] BYTE_STEP = 16'h0001;
  localparam logic [DATA_W-1:0] EVEN_MASK = 16'hfffe;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  typedef enum logic [2:0]
  {
    OP_PUSH   = 3'h0,
    OP_POP    = 3'h1,
    OP_CALL   = 3'h2,
    OP_RETURN = 3'h3,
    OP_INTR   = 3'h4
  } spa_op_t;

  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'h01,
    ST_DEC   = 6'h02,
    ST_WRITE = 6'h04,
    ST_READ  = 6'h08,
    ST_INC   = 6'h10,
    ST_LINK  = 6'h20
  } spa_state_t;
endpackage

// File: spa_rf_if.sv
// register file access port shared by the unit and its register file
`timescale 1ns/100ps
interface spa_rf_if;
  logic [spa_pkg::REG_W-1:0]  rd_sel;
  logic [spa_pkg::DATA_W-1:0] rd_data;
  logic [spa_pkg::REG_W-1:0]  wr_sel;
  logic [spa_pkg::DATA_W-1:0] wr_data;
  logic                       wr_en;
  modport unit (output rd_sel, input rd_data, output wr_sel,
                output wr_data, output wr_en);
  modport regs (input rd_sel, output rd_data, input wr_sel,
                input wr_data, input wr_en);
endinterface

// File: spa_regfile.sv
// eight general registers with one read and one write port
`timescale 1ns/100ps
module spa_regfile
(
  input  wire logic clk,
  input  wire logic nrst,
  spa_rf_if.regs    rf
);
  logic [spa_pkg::DATA_W-1:0] regs_q [8];

  assign rf.rd_data = regs_q[rf.rd_sel];

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_reg
      localparam logic [spa_pkg::REG_W-1:0] IDX = spa_pkg::REG_W'(g);
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          regs_q[g] <= spa_pkg::ZERO_WORD;
        else if (rf.wr_en && rf.wr_sel == IDX)
          regs_q[g] <= rf.wr_data;
      end
    end
  endgenerate
endmodule

// File: spa_unit.sv
// stack pointer address unit: push, pop, call and return sequencing
`timescale 1ns/100ps
module spa_unit
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire spa_pkg::spa_op_t           req_op,
  input  wire logic [spa_pkg::REG_W-1:0]  req_reg,
  input  wire logic                       req_byte,
  input  wire logic [spa_pkg::DATA_W-1:0] req_data,
  input  wire logic [spa_pkg::DATA_W-1:0] req_target,
  output logic                            req_error,
  output logic                            done,
  output logic [spa_pkg::DATA_W-1:0]      pop_data_q,
  output logic                            mem_valid,
  output logic                            mem_write,
  output logic                            mem_byte,
  output logic [spa_pkg::DATA_W-1:0]      mem_addr_q,
  output logic [spa_pkg::DATA_W-1:0]      mem_wdata_q,
  input  wire logic                       mem_ready,
  input  wire logic [spa_pkg::DATA_W-1:0] mem_rdata
);
  spa_rf_if rf ();

  spa_regfile u_regs
  (
    .clk  (clk),
    .nrst (nrst),
    .rf   (rf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic [spa_pkg::DATA_W-1:0] step_of
  (
    input logic [spa_pkg::REG_W-1:0] r,
    input logic                      b
  );
    step_of = (b && r != spa_pkg::SYS_STACK_REG) ? spa_pkg::BYTE_STEP
                                                 : spa_pkg::WORD_STEP; // RQ11
  endfunction

  spa_pkg::spa_state_t         state_q;
  spa_pkg::spa_state_t         state_d;
  spa_pkg::spa_op_t            op_q;
  logic [spa_pkg::REG_W-1:0]   ptr_q;
  logic [spa_pkg::REG_W-1:0]   link_q;
  logic                        byte_q;
  logic [spa_pkg::DATA_W-1:0]  data_q;
  logic [spa_pkg::DATA_W-1:0]  target_q;
  logic [spa_pkg::DATA_W-1:0]  ptr_val;
  logic [spa_pkg::DATA_W-1:0]  ptr_dec;
  logic [spa_pkg::DATA_W-1:0]  ptr_inc;
  logic [spa_pkg::DATA_W-1:0]  ptr_step;
  logic [spa_pkg::REG_W-1:0]   sel_ptr;
  logic                        eff_byte;
  logic                        bad_reg;
  logic                        idle;
  logic                        mem_done;
  logic [spa_pkg::REG_W-1:0]   idle_sel;
  logic [spa_pkg::DATA_W-1:0]  link_val_q;
  logic [spa_pkg::DATA_W-1:0]  regs_peek;
  logic [spa_pkg::DATA_W-1:0]  mem_rdata_hold;

  // calls, returns and interrupts ignore the named register for stacking
  assign sel_ptr  = (req_op == spa_pkg::OP_PUSH || req_op == spa_pkg::OP_POP)
                    ? req_reg : spa_pkg::SYS_STACK_REG; // RQ4
  assign eff_byte = req_byte && sel_ptr != spa_pkg::SYS_STACK_REG; // RQ5
  assign bad_reg  = req_reg == spa_pkg::INSTR_COUNTER_REG &&
                    (req_op == spa_pkg::OP_PUSH ||
                     req_op == spa_pkg::OP_POP); // RQ3
  assign idle     = state_q == spa_pkg::ST_IDLE;
  assign req_ready = idle;
  assign req_error = idle && req_valid && bad_reg;
  assign mem_done  = mem_valid && mem_ready;
  assign mem_valid = state_q == spa_pkg::ST_WRITE ||
                     state_q == spa_pkg::ST_READ;
  assign mem_write = state_q == spa_pkg::ST_WRITE;
  assign mem_byte  = byte_q;

  assign ptr_val  = rf.rd_data;
  assign ptr_step = step_of(ptr_q, byte_q);
  assign ptr_dec  = ptr_val - ptr_step; // RQ1
  assign ptr_inc  = ptr_val + ptr_step;

  ////////////////////////////////////////////////////////////////////////////
  // register file port

  // one read port: while idle it serves the link value or the pop address
  assign idle_sel  = (req_op == spa_pkg::OP_CALL) ? req_reg : sel_ptr;
  assign rf.rd_sel = (state_q == spa_pkg::ST_LINK) ? link_q
                   : idle ? idle_sel : ptr_q;

  always_comb
  begin
    rf.wr_en   = 1'b0;
    rf.wr_sel  = ptr_q;
    rf.wr_data = ptr_dec;
    case (state_q)
      spa_pkg::ST_DEC:
      begin
        rf.wr_en = 1'b1; // RQ6
        // byte steps never reach the system stack, so it stays even
        if (ptr_q == spa_pkg::SYS_STACK_REG)
          rf.wr_data = ptr_dec & spa_pkg::EVEN_MASK; // RQ8
      end
      spa_pkg::ST_INC:
      begin
        rf.wr_en   = 1'b1; // RQ7
        rf.wr_data = (ptr_q == spa_pkg::SYS_STACK_REG)
                     ? (ptr_inc & spa_pkg::EVEN_MASK) : ptr_inc; // RQ8
      end
      spa_pkg::ST_LINK:
      begin
        rf.wr_en   = 1'b1;
        rf.wr_sel  = link_q;
        rf.wr_data = data_q; // RQ9 RQ10
        if (op_q == spa_pkg::OP_RETURN)
          rf.wr_data = mem_rdata_hold;
      end
      default:
      begin
        rf.wr_en = 1'b0;
      end
    endcase
  end

  assign mem_rdata_hold = pop_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      spa_pkg::ST_IDLE:
        if (req_valid && !bad_reg)
          state_d = (req_op == spa_pkg::OP_POP ||
                     req_op == spa_pkg::OP_RETURN)
                    ? spa_pkg::ST_READ : spa_pkg::ST_DEC;
      spa_pkg::ST_DEC:
        state_d = spa_pkg::ST_WRITE;
      spa_pkg::ST_WRITE:
        if (mem_ready)
          state_d = (op_q == spa_pkg::OP_CALL) ? spa_pkg::ST_LINK
                                               : spa_pkg::ST_IDLE;
      spa_pkg::ST_READ:
        if (mem_ready)
          state_d = spa_pkg::ST_INC;
      spa_pkg::ST_INC:
        state_d = (op_q == spa_pkg::OP_RETURN) ? spa_pkg::ST_LINK
                                               : spa_pkg::ST_IDLE;
      spa_pkg::ST_LINK:
        state_d = spa_pkg::ST_IDLE;
      default:
        state_d = spa_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= spa_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op_q     <= spa_pkg::OP_PUSH;
      ptr_q    <= spa_pkg::SYS_STACK_REG;
      link_q   <= spa_pkg::SYS_STACK_REG;
      byte_q   <= 1'b0;
      data_q   <= spa_pkg::ZERO_WORD;
      target_q <= spa_pkg::ZERO_WORD;
    end
    else if (idle && req_valid && !bad_reg)
    begin
      op_q     <= req_op;
      ptr_q    <= sel_ptr;
      link_q   <= req_reg;
      byte_q   <= eff_byte;
      data_q   <= req_data;
      target_q <= req_target;
    end
  end

  // rf read port is single, so the linkage value is captured for the write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mem_wdata_q <= spa_pkg::ZERO_WORD;
    else if (state_q == spa_pkg::ST_DEC)
      mem_wdata_q <= (op_q == spa_pkg::OP_CALL) ? link_val_q : data_q;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      link_val_q <= spa_pkg::ZERO_WORD;
    else if (idle)
      link_val_q <= regs_peek;
  end

  assign regs_peek = rf.rd_data;

  // address is the pointer after the decrement, or as it stands for a read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mem_addr_q <= spa_pkg::ZERO_WORD;
    else if (state_q == spa_pkg::ST_DEC)
      mem_addr_q <= rf.wr_data; // RQ2 RQ6
    else if (idle && state_d == spa_pkg::ST_READ)
      mem_addr_q <= ptr_val; // RQ7
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pop_data_q <= spa_pkg::ZERO_WORD;
    else if (state_q == spa_pkg::ST_READ && mem_ready)
      pop_data_q <= mem_rdata;
  end

  assign done = (state_q == spa_pkg::ST_LINK) ||
                (state_q == spa_pkg::ST_INC && op_q != spa_pkg::OP_RETURN) ||
                (state_q == spa_pkg::ST_WRITE && mem_ready &&
                 op_q != spa_pkg::OP_CALL);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_push_lowers_ptr: assert property (@(posedge clk) disable iff (!nrst) // RQ6
    state_q == spa_pkg::ST_DEC |=>
      mem_addr_q == ptr_val &&
      mem_addr_q == $past(ptr_val) - $past(ptr_step))
    else $error("push did not lower the pointer");
  a_sys_words: assert property (@(posedge clk) disable iff (!nrst) // RQ5
    mem_valid && ptr_q == spa_pkg::SYS_STACK_REG |-> !mem_byte)
    else $error("byte access on system stack");
  a_sys_even: assert property (@(posedge clk) disable iff (!nrst) // RQ8
    rf.wr_en && rf.wr_sel == spa_pkg::SYS_STACK_REG && state_q != spa_pkg::ST_LINK
    |-> !rf.wr_data[0])
    else $error("system stack made odd");
  a_pc_refused: assert property (@(posedge clk) disable iff (!nrst) // RQ3
    idle && req_valid && bad_reg |=> idle)
    else $error("counter register used as pointer");
  a_pop_then_inc: assert property (@(posedge clk) disable iff (!nrst) // RQ7
    state_q == spa_pkg::ST_READ && mem_ready |=> state_q == spa_pkg::ST_INC)
    else $error("pop did not raise pointer");
  sequence s_call_pushed;
    state_q == spa_pkg::ST_WRITE && mem_ready && op_q == spa_pkg::OP_CALL;
  endsequence
  a_call_links: assert property (@(posedge clk) disable iff (!nrst) // RQ9
    s_call_pushed |=> state_q == spa_pkg::ST_LINK)
    else $error("call did not load linkage");
endmodule

// File: spa_mem_model.sv
// behavioural memory answering the unit's memory requests
`timescale 1ns/100ps
module spa_mem_model
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_valid,
  input  wire logic        mem_write,
  input  wire logic        mem_byte,
  input  wire logic [15:0] mem_addr_q,
  input  wire logic [15:0] mem_wdata_q,
  output logic             mem_ready,
  output logic [15:0]      mem_rdata
);
  logic [7:0]  mem [logic [15:0]];
  logic [3:0]  wait_q;
  logic [15:0] last_waddr;
  logic [15:0] last_wdata;
  logic [15:0] last_raddr;
  int          n_wr;
  int          n_rd;
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  // data is not held once ready drops: the bus toggles every idle cycle
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      mem_ready <= 1'b0;
      mem_rdata <= 16'h5a5a;
      wait_q    <= 4'h0;
    end
    else if (mem_ready)
    begin
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_write)
      begin
        if (mem_byte)
          mem[mem_addr_q] = mem_wdata_q[7:0];
        else
        begin
          mem[mem_addr_q & 16'hfffe] = mem_wdata_q[7:0];
          mem[mem_addr_q | 16'h0001] = mem_wdata_q[15:8];
        end
        last_waddr = mem_addr_q;
        last_wdata = mem_wdata_q;
        n_wr++;
      end
      else
      begin
        last_raddr = mem_addr_q;
        n_rd++;
      end
    end
    else if (mem_valid && wait_q == lat)
    begin
      mem_ready <= 1'b1;
      wait_q    <= 4'h0;
      mem_rdata <= {rd(mem_addr_q | 16'h0001), rd(mem_addr_q & 16'hfffe)};
    end
    else
    begin
      wait_q    <= mem_valid ? wait_q + 4'h1 : 4'h0;
      mem_rdata <= ~mem_rdata;
    end
endmodule

// File: tb.sv
// self-checking bench for the stack pointer address unit
`timescale 1ns/100ps
module tb;
  logic             clk;
  logic             nrst;
  logic             req_valid;
  logic             req_ready;
  spa_pkg::spa_op_t req_op;
  logic [2:0]       req_reg;
  logic             req_byte;
  logic [15:0]      req_data;
  logic             req_error;
  logic             done;
  logic [15:0]      pop_data_q;
  logic             mem_valid;
  logic             mem_write;
  logic             mem_byte;
  logic [15:0]      mem_addr_q;
  logic [15:0]      mem_wdata_q;
  logic             mem_ready;
  logic [15:0]      mem_rdata;
  logic [3:0]       lat;
  logic [15:0]      ptr [8];
  int               n_fail;
  int               n_compared;
  int               cycles;
  spa_unit u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_reg(req_reg),
    .req_byte(req_byte), .req_data(req_data), .req_target(~req_data),
    .req_error(req_error), .done(done), .pop_data_q(pop_data_q),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_byte(mem_byte),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  spa_mem_model u_mem (.clk(clk), .nrst(nrst), .lat(lat),
    .mem_valid(mem_valid), .mem_write(mem_write), .mem_byte(mem_byte),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata));
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  function automatic logic [15:0] step(input logic [2:0] r, input logic b);
    return (b && r != spa_pkg::SYS_STACK_REG) ? spa_pkg::BYTE_STEP
                                              : spa_pkg::WORD_STEP;
  endfunction
  // done is looked at in every cycle; a push or interrupt write lands one edge later
  task automatic issue(input spa_pkg::spa_op_t op, input logic [2:0] r,
                       input logic b, input logic [15:0] d);
    int i;
    @(posedge clk);
    req_op    <= op;
    req_reg   <= r;
    req_byte  <= b;
    req_data  <= d;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 40 && done !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk({15'h0, done}, 16'h0001, "no completion");
    @(posedge clk);
    #1;
  endtask
  task automatic t_push(input logic [2:0] r, input logic b,
                        input logic [15:0] d);
    logic [15:0] m;
    ptr[r] = ptr[r] - step(r, b);
    m = b ? 16'h00ff : 16'hffff;
    issue(spa_pkg::OP_PUSH, r, b, d);
    chk(u_mem.last_waddr, ptr[r], "push address");
    chk(u_mem.last_wdata & m, d & m, "push data");
  endtask
  task automatic t_pop(input logic [2:0] r, input logic b,
                       input logic [15:0] d);
    logic [15:0] lane;
    issue(spa_pkg::OP_POP, r, b, 16'h0000);
    chk(u_mem.last_raddr, ptr[r], "pop address");
    // a byte at an odd address arrives in the upper lane
    lane = ptr[r][0] ? pop_data_q >> 8 : pop_data_q & 16'h00ff;
    if (!b)
      chk(pop_data_q, d, "pop data");
    else
      chk(lane, d & 16'h00ff, "pop byte");
    ptr[r] = ptr[r] + step(r, b);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic s_word_stack();
    int r;
    for (r = 0; r < 6; r++)
    begin
      lat = r[3:0];
      t_push(r[2:0], 1'b0, 16'h1234 + r[15:0]);
      t_push(r[2:0], 1'b0, 16'habcd);
      t_pop(r[2:0], 1'b0, 16'habcd);
      t_pop(r[2:0], 1'b0, 16'h1234 + r[15:0]);
    end
    t_push(3'h3, 1'b0, 16'h0f0f);
  endtask
  task automatic s_byte_stack();
    lat = 4'h2;
    t_push(3'h2, 1'b1, 16'h0041);
    t_push(3'h2, 1'b1, 16'h0042);
    t_pop(3'h2, 1'b1, 16'h0042);
    t_push(3'h6, 1'b1, 16'h0077);
    chk({15'h0, u_mem.last_waddr[0]}, 16'h0000, "odd system stack");
    t_pop(3'h6, 1'b1, 16'h0077);
  endtask
  task automatic s_refuse();
    int k;
    int n;
    n = u_mem.n_wr + u_mem.n_rd;
    for (k = 0; k < 2; k++)
    begin
      @(posedge clk);
      req_op    <= k ? spa_pkg::OP_POP : spa_pkg::OP_PUSH;
      req_reg   <= 3'h7;
      req_valid <= 1'b1;
      #1;
      chk({15'h0, req_error}, 16'h0001, "no refusal");
      chk({15'h0, req_ready}, 16'h0001, "not ready while idle");
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk({15'h0, mem_valid}, 16'h0000, "refused access ran");
    end
    chk(16'(u_mem.n_wr + u_mem.n_rd - n), 16'h0000, "memory touched");
  endtask
  task automatic s_intr_call();
    logic [15:0] saved;
    lat = 4'h1;
    ptr[6] = ptr[6] - 16'h0002;
    issue(spa_pkg::OP_INTR, 3'h3, 1'b1, 16'h5511);
    chk(u_mem.last_waddr, ptr[6], "interrupt push address");
    chk(u_mem.last_wdata, 16'h5511, "interrupt push data");
    ptr[6] = ptr[6] - 16'h0002;
    issue(spa_pkg::OP_CALL, 3'h3, 1'b0, 16'h2468);
    chk(u_mem.last_waddr, ptr[6], "call push address");
    chk(u_mem.last_wdata, ptr[3], "call saved link");
    // the linkage register now holds the return address
    saved  = ptr[3];
    ptr[3] = 16'h2468;
    t_push(3'h3, 1'b0, 16'h1111);
    t_pop(3'h3, 1'b0, 16'h1111);
    ptr[3] = saved;
    issue(spa_pkg::OP_RETURN, 3'h3, 1'b0, 16'h0000);
    chk(u_mem.last_raddr, ptr[6], "return pop address");
    chk(pop_data_q, saved, "return popped link");
    ptr[6] = ptr[6] + 16'h0002;
    t_push(3'h3, 1'b0, 16'h1357);
    t_pop(3'h6, 1'b0, 16'h5511);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    nrst      = 1'b0;
    req_valid = 1'b0;
    req_op    = spa_pkg::OP_PUSH;
    req_reg   = 3'h0;
    req_byte  = 1'b0;
    req_data  = 16'h0000;
    lat       = 4'h0;
    foreach (ptr[i])
      ptr[i] = 16'h0000;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    s_word_stack();
    s_byte_stack();
    s_refuse();
    s_intr_call();
    conclude();
  end
endmodule
